// *** verilog/ret_exec_pkg.sv ***
/*
 * constants, types and decode helpers shared by the return-instruction
 * execution logic and its quarter-phase sequencer.
 * assumes a core that supplies the fetched word, the stack top and the
 * shadow registers, and applies the one-clock write strobes it receives.
 */
package ret_exec_pkg;

    // ==========================================================
    // quarter phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // ==========================================================
    // opcode layout
    localparam logic [15:0] IRQ_RET_WORD = 16'h0010;
    localparam logic [15:0] IRQ_RET_MASK = 16'hfffe;
    localparam logic [7:0] LIT_RET_HIGH = 8'h0c;
    localparam int FAST_BIT = 0;
    localparam int LIT_MSB = 7;
    localparam int PC_WIDTH = 21;

    typedef struct packed {
        logic [7:0] working;
        logic [7:0] status;
        logic [7:0] bank_select;
    } core_regs_t;

    function automatic logic is_ret_irq(input logic [15:0] w);
        return (w & IRQ_RET_MASK) == IRQ_RET_WORD;
    endfunction

    function automatic logic is_ret_lit(input logic [15:0] w);
        return w[15:8] == LIT_RET_HIGH;
    endfunction

endpackage

// *** verilog/q_phase_gen.sv ***
/*
 * quarter-phase sequencer: steps Q1..Q4 once per clock, forever.
 * assumes one system clock edge per quarter phase.
 */
`timescale 1ns/1ps
`default_nettype none

module q_phase_gen import ret_exec_pkg::*; (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // phase
    output logic [1:0] o_phase
);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_phase <= PH_Q1;
        end else begin
            o_phase <= o_phase + 2'h1;
        end
    end

endmodule

`default_nettype wire

// *** verilog/return_instruction_exec.sv ***
/*
 * execution of the two return instructions of the core: return from
 * interrupt (optionally restoring shadows) and return with literal.
 * assumes the core offers the fetched word with i_instr_valid during Q1,
 * keeps the stack top and shadows valid while busy, and applies every
 * o_*_we / o_*_set / o_stack_pop strobe as a one-clock write in Q4.
 * the counter latches are never driven from here.
 */
`timescale 1ns/1ps
`default_nettype none

module return_instruction_exec import ret_exec_pkg::*; #(
    parameter int PC_W = PC_WIDTH
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // fetched instruction
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    // core state
    input wire logic [PC_W-1:0] i_stack_top,
    input wire core_regs_t i_shadow,
    input wire logic i_prio_enable,
    input wire logic i_in_high_isr,
    // program counter and stack
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_stack_pop,
    // register file writes
    output logic o_working_we,
    output logic o_status_we,
    output logic o_bank_select_we,
    output core_regs_t o_regs,
    // interrupt enables
    output logic o_high_irq_en_set,
    output logic o_low_irq_en_set,
    // sequencing
    output logic o_busy,
    output logic [1:0] o_q_phase
);

    if (PC_W < 1 || PC_W > 32) begin : g_bad_width
        $error("PC_W out of range");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} exec_state_t;

    exec_state_t state_q;
    logic [1:0] phase;
    logic take;
    logic irq_op_q;
    logic fast_q;
    logic [7:0] literal_q;
    logic prio_q;
    logic high_q;

    // ==========================================================
    // quarter phases
    q_phase_gen u_phase (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .o_phase(phase)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_q_phase <= PH_Q1;
        end else begin
            o_q_phase <= phase + 2'h1;
        end
    end

    // ==========================================================
    // decode: only accepted at Q1 while idle; other words are not ours
    assign take = (state_q == ST_IDLE) && (phase == PH_Q1) && i_instr_valid
                  && (is_ret_irq(i_instr) || is_ret_lit(i_instr));

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            irq_op_q <= 1'b0;
            fast_q <= 1'b0;
            literal_q <= 8'h00;
            prio_q <= 1'b0;
            high_q <= 1'b0;
        end else if (take) begin
            irq_op_q <= is_ret_irq(i_instr);
            fast_q <= is_ret_irq(i_instr) && i_instr[FAST_BIT];
            literal_q <= i_instr[LIT_MSB:0];
            prio_q <= i_prio_enable;
            high_q <= i_in_high_isr;
        end
    end

    // ==========================================================
    // two instruction cycles: execute cycle, then a no-operation cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            o_busy <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_EXEC;
                        o_busy <= 1'b1;
                    end
                end
                ST_EXEC: begin
                    if (phase == PH_Q4) begin
                        state_q <= ST_NOP;
                    end
                end
                ST_NOP: begin
                    if (phase == PH_Q4) begin
                        state_q <= ST_IDLE;
                        o_busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Q4 strobes of the execute cycle
    logic fire;
    assign fire = (state_q == ST_EXEC) && (phase == PH_Q3);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_pc_load <= 1'b0;
            o_stack_pop <= 1'b0;
            o_pc_value <= '0;
        end else begin
            o_pc_load <= fire;
            o_stack_pop <= fire;
            if (fire) begin
                o_pc_value <= i_stack_top;
            end
        end
    end

    // status and bank select only change on a fast interrupt return
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_working_we <= 1'b0;
            o_status_we <= 1'b0;
            o_bank_select_we <= 1'b0;
            o_regs <= '0;
        end else begin
            o_working_we <= fire && (!irq_op_q || fast_q);
            o_status_we <= fire && fast_q;
            o_bank_select_we <= fire && fast_q;
            if (fire) begin
                o_regs <= irq_op_q ? i_shadow
                                   : core_regs_t'{working: literal_q, status: 8'h00, bank_select: 8'h00};
            end
        end
    end

    // flat mode has a single global enable, carried on the high bit
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_high_irq_en_set <= 1'b0;
            o_low_irq_en_set <= 1'b0;
        end else begin
            o_high_irq_en_set <= fire && irq_op_q && (!prio_q || high_q);
            o_low_irq_en_set <= fire && irq_op_q && prio_q && !high_q;
        end
    end

    // ==========================================================
    // checks
    sequence s_take_irq;
        take && is_ret_irq(i_instr);
    endsequence

    sequence s_take_lit;
        take && is_ret_lit(i_instr);
    endsequence

    sequence s_q4_strobe;
        ##3 o_pc_load && o_stack_pop;
    endsequence

    pc_pop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        s_take_irq |-> s_q4_strobe ##0 (o_pc_value == $past(i_stack_top)))
        else $error("interrupt return did not reload pc from stack");
    irq_enable_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        s_take_irq |-> ##3 (o_high_irq_en_set != o_low_irq_en_set))
        else $error("interrupt return did not set exactly one enable");
    fast_restore_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        s_take_irq ##0 i_instr[FAST_BIT] |-> ##3 o_working_we && o_status_we && o_bank_select_we
            && (o_regs == $past(i_shadow)))
        else $error("fast return did not restore shadows");
    no_restore_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        s_take_irq ##0 !i_instr[FAST_BIT] |-> ##3 !o_working_we && !o_status_we && !o_bank_select_we)
        else $error("plain return wrote core registers");
    strobe_pair_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        o_pc_load |-> o_stack_pop && $past(state_q) == ST_EXEC && o_q_phase == PH_Q4)
        else $error("pc load outside execute quarter four");
    two_cycles_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        take |-> ##1 o_busy [*7] ##1 !o_busy)
        else $error("return did not take two instruction cycles");
    literal_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        s_take_lit |-> s_q4_strobe ##0 o_working_we && (o_regs.working == $past(i_instr[LIT_MSB:0], 3)))
        else $error("literal return did not write literal");
    literal_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        s_take_lit |-> ##1 (!o_status_we && !o_bank_select_we && !o_high_irq_en_set && !o_low_irq_en_set) [*7])
        else $error("literal return touched status or enables");
    low_prio_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        s_take_irq ##0 (i_prio_enable && !i_in_high_isr) |-> ##3 o_low_irq_en_set && !o_high_irq_en_set)
        else $error("low priority return set wrong enable");

endmodule

`default_nettype wire

// *** test/return_instruction_exec_tb.sv ***
/*
 * self-checking bench for the return-instruction execution block.
 * assumes the package and design files are compiled first; the bench
 * plays the core, holding stack top and shadows steady during each op.
 */
`timescale 1ns/1ps
`default_nettype none

module return_instruction_exec_tb import ret_exec_pkg::*;;

    // ==========================================================
    // signals
    logic i_sys_clk;
    logic i_rstn;
    logic i_instr_valid;
    logic [15:0] i_instr;
    logic [PC_WIDTH-1:0] i_stack_top;
    core_regs_t i_shadow;
    logic i_prio_enable;
    logic i_in_high_isr;
    logic o_pc_load;
    logic [PC_WIDTH-1:0] o_pc_value;
    logic o_stack_pop;
    logic o_working_we;
    logic o_status_we;
    logic o_bank_select_we;
    core_regs_t o_regs;
    logic o_high_irq_en_set;
    logic o_low_irq_en_set;
    logic o_busy;
    logic [1:0] o_q_phase;
    int err_total;
    int n_tests;

    return_instruction_exec #(.PC_W(PC_WIDTH)) i_dut (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .i_stack_top(i_stack_top), .i_shadow(i_shadow), .i_prio_enable(i_prio_enable),
        .i_in_high_isr(i_in_high_isr), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
        .o_stack_pop(o_stack_pop), .o_working_we(o_working_we), .o_status_we(o_status_we),
        .o_bank_select_we(o_bank_select_we), .o_regs(o_regs), .o_high_irq_en_set(o_high_irq_en_set),
        .o_low_irq_en_set(o_low_irq_en_set), .o_busy(o_busy), .o_q_phase(o_q_phase)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    // ==========================================================
    // shared helpers
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // offers one word at an idle Q1 and watches the eight clocks after the take;
    // exp_s = {pc_load, pop, working, status, bank, high_en, low_en}, zero means refused.
    // hold keeps the word valid while busy, which must not start a second op.
    task automatic exec_op(input logic [15:0] w, input logic hold, input logic [6:0] exp_s,
                           input logic [23:0] exp_r, input logic [23:0] mask);
        logic [6:0] s;
        int guard;
        guard = 0;
        @(negedge i_sys_clk);
        while (!(o_q_phase === 2'h0 && o_busy === 1'b0) && guard < 8) begin
            guard++;
            @(negedge i_sys_clk);
        end
        i_instr = w;
        i_instr_valid = 1'b1;
        for (int n = 1; n <= 8; n++) begin
            @(negedge i_sys_clk);
            if (!hold || n == 7) i_instr_valid = 1'b0;
            s = {o_pc_load, o_stack_pop, o_working_we, o_status_we, o_bank_select_we,
                 o_high_irq_en_set, o_low_irq_en_set};
            chk(s === (n == 3 ? exp_s : 7'h00), "strobe pattern");
            chk(o_busy === (exp_s != 7'h00 && n < 8), "busy span");
            if (n == 3 && exp_s != 7'h00) begin
                chk(o_q_phase === 2'h3, "strobes outside last quarter");
                chk(o_pc_value === i_stack_top, "program counter value");
                chk(((o_regs ^ exp_r) & mask) === 24'h0, "register write data");
            end
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_irq_flat();
        i_prio_enable = 1'b0;
        i_stack_top = 21'h1f00a5;
        for (int h = 0; h < 2; h++) begin
            i_in_high_isr = h[0];
            exec_op(16'h0010, 1'b0, 7'b1100010, 24'h0, 24'h0);
        end
    endtask

    task automatic t_irq_fast();
        i_prio_enable = 1'b1;
        i_shadow = 24'ha53c0f;
        for (int h = 0; h < 2; h++) begin
            i_in_high_isr = h[0];
            i_stack_top = h[0] ? 21'h1fffff : 21'h000001;
            exec_op(16'h0011, 1'b0, {5'b11111, h[0], !h[0]}, 24'ha53c0f, 24'hffffff);
        end
    endtask

    task automatic t_lit();
        logic [7:0] k [3] = '{8'h00, 8'h5a, 8'hff};
        i_shadow = 24'h3c7e81;
        for (int j = 0; j < 3; j++)
            exec_op({8'h0c, k[j]}, 1'b0, 7'b1110000, {k[j], 16'h0}, 24'hff0000);
    endtask

    task automatic t_refused();
        logic [15:0] w [4] = '{16'h0012, 16'h0d00, 16'h0b00, 16'h0001};
        for (int j = 0; j < 4; j++)
            exec_op(w[j], 1'b0, 7'h00, 24'h0, 24'h0);
    endtask

    task automatic t_hold_busy();
        i_stack_top = 21'h0a5a5a;
        exec_op(16'h0cc3, 1'b1, 7'b1110000, 24'hc30000, 24'hff0000);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        err_total = 0;
        n_tests = 0;
        i_rstn = 1'b0;
        i_instr_valid = 1'b0;
        i_instr = 16'h0;
        i_stack_top = '0;
        i_shadow = '0;
        i_prio_enable = 1'b0;
        i_in_high_isr = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rstn = 1'b1;
        t_irq_flat();
        t_irq_fast();
        t_lit();
        t_refused();
        t_hold_busy();
        complete_run();
    end

    // twelve ops of a dozen clocks each; ample margin for a hang
    initial begin
        #(3000 * 100);
        err_total++;
        complete_run();
    end

endmodule

`default_nettype wire
